// [ilk_diag.sv]
// Interlock status, fault timing, LED flash codes and register slave
//
// Overview of operation
// - Status pin high only with guard closed and interlock able to lock.
// - Channel A test fault: one red pulse, channels off after 30 min.
// - Channel B test fault: two red pulses, channels off after 30 min.
// - Cross connection or both faults: three pulses, off after 30 min, power cycle.
// - Wrong or defective actuator: five pulses, channels off at once.
// - Holding force unreachable: six pulses, channels off at once.
// - Magnet over temperature: ten pulses, channels off at once.
// - Internal failure: red steady while guard closed, channels off while it persists.
// - Cross connection and channel shorts are delayed shutdown cases.
// - Latched failure clears only after cause gone and guard opened then closed.
// - After a cleared failure, relocking re-enables both channels.
// - Warning keeps channels on for 30 min, then forces them off.
// - Warning clears itself when its cause disappears.
// - Green LED lit whenever powered and ready.
// - Yellow LED flashes when actuator sits near sensing limit.
// - Red LED shows the flash code for any latched failure or warning while the guard is closed.
// - Closed, actuator in, no lock command: yellow flashes, channels low, status high.
// - Closed, commanded and locked: yellow steady, channels and status high.
// - Closed, commanded, force too low: yellow flashes, channels and status low.
`timescale 1ns/1ps
module ilk_diag
    import ilk_pkg::*;
#(
    parameter logic [TMR_W-1:0] WARN_CYCLES   = TMR_W'(WARN_CYC),
    parameter logic [FT_W-1:0]  FLASH_ON      = FT_W'(FLASH_ON_CYC),
    parameter logic [FT_W-1:0]  FLASH_PAUSE   = FT_W'(FLASH_PAUSE_CYC),
    parameter logic [FT_W-1:0]  YEL_HALF      = FT_W'(YEL_HALF_CYC)
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    input  wire ilk_pins_t   pins,
    output logic             safety_channel_a,
    output logic             safety_channel_b,
    output logic             status_out,
    output logic             led_green,
    output logic             led_yellow,
    output logic             led_red
);
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    ilk_pins_t        p;
    logic [31:0]      ctrl;
    ilk_bus_q_t       bq;
    logic [TMR_W-1:0] warn_cnt;
    logic             fail_latched;
    logic             fail_power;
    logic [3:0]       fail_code;
    logic             saw_open;
    logic [FT_W-1:0]  fl_tmr;
    logic [3:0]       fl_left;
    ilk_fl_state_t    fl_state;
    logic [FT_W-1:0]  yel_tmr;
    logic             yel_blink;

    // Two-flop synchronisers on every pin input
    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++) begin : g_sync
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sync1[gi] <= 1'b0;
                    sync2[gi] <= 1'b0;
                end else begin
                    sync1[gi] <= pins[gi];
                    sync2[gi] <= sync1[gi];
                end
            end
        end
    endgenerate
    assign p = ilk_pins_t'(sync2);

    // Fault classification
    wire lock_cmd    = p.solenoid_cmd | ctrl[CTRL_LOCK];
    wire both_ab     = p.test_fault_a & p.test_fault_b;
    wire cross_cause = p.cross_connect | both_ab;
    wire warn_cause  = p.test_fault_a | p.test_fault_b | p.cross_connect;
    wire [3:0] warn_code = cross_cause    ? CODE_CROSS :
                           p.test_fault_a ? CODE_A :
                           CODE_B;
    wire imm_cause   = p.actuator_wrong | p.force_fault | p.magnet_over_temp;
    wire [3:0] imm_code  = p.actuator_wrong ? CODE_ACT :
                           p.force_fault    ? CODE_FORCE :
                           CODE_TEMP;
    wire warn_expired = warn_cause && (warn_cnt == WARN_CYCLES - TMR_W'(1));
    wire cause_now    = warn_cause | imm_cause;
    wire fail_set     = !fail_latched && (imm_cause || warn_expired);
    wire fail_clear   = fail_latched && !fail_power && !cause_now
                        && saw_open && p.guard_closed;

    // Warning timer: counts while cause stands, restarts when it clears
    wire [TMR_W-1:0] next_warn_cnt = !warn_cause   ? '0 :
                                     warn_expired  ? warn_cnt :
                                     warn_cnt + TMR_W'(1);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            warn_cnt <= '0;
        end else begin
            warn_cnt <= next_warn_cnt;
        end
    end

    // Failure latch; cross connection needs a power cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fail_latched <= 1'b0;
            fail_power   <= 1'b0;
            fail_code    <= CODE_NONE;
            saw_open     <= 1'b0;
        end else begin
            if (fail_set) begin
                fail_latched <= 1'b1;
                fail_power   <= !imm_cause && cross_cause;
                fail_code    <= imm_cause ? imm_code : warn_code;
                saw_open     <= 1'b0;
            end else if (fail_clear) begin
                fail_latched <= 1'b0;
                fail_code    <= CODE_NONE;
                saw_open     <= 1'b0;
            end else if (fail_latched && !cause_now && !p.guard_closed) begin
                saw_open     <= 1'b1;
            end
        end
    end

    // Output conditions
    wire failed    = fail_latched | p.internal_failure;
    wire locked    = p.guard_closed & lock_cmd & p.lock_achieved & !p.force_fault;
    wire ch_on     = locked & ctrl[CTRL_ENABLE] & !failed;
    wire can_lock  = p.guard_closed & p.actuator_present & !lock_cmd;
    wire next_stat = p.guard_closed & !failed & !warn_cause
                     & (locked | can_lock);
    wire [3:0] red_code = fail_latched ? fail_code :
                          warn_cause   ? warn_code : CODE_NONE;
    wire yel_steady = locked & !p.actuator_near_limit;
    wire yel_flash  = p.actuator_present | p.actuator_near_limit;
    wire next_yel   = p.guard_closed && !failed
                      && (yel_steady || (yel_flash && yel_blink));
    wire next_red   = p.guard_closed && (p.internal_failure ||
                      fl_state == FL_ON);

    // Yellow blink base
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            yel_tmr   <= '0;
            yel_blink <= 1'b0;
        end else if (yel_tmr == YEL_HALF - FT_W'(1)) begin
            yel_tmr   <= '0;
            yel_blink <= !yel_blink;
        end else begin
            yel_tmr   <= yel_tmr + FT_W'(1);
        end
    end

    // Red flash code sequencer: burst, pause, repeat
    wire fl_done = (fl_tmr == '0);
    ilk_fl_state_t   next_fl_state;
    logic [FT_W-1:0] next_fl_tmr;
    logic [3:0]      next_fl_left;
    always_comb begin
        next_fl_state = fl_state;
        next_fl_tmr   = fl_done ? '0 : fl_tmr - FT_W'(1);
        next_fl_left  = fl_left;
        case (fl_state)
            FL_IDLE: begin
                if (red_code != CODE_NONE) begin
                    next_fl_state = FL_ON;
                    next_fl_tmr   = FLASH_ON - FT_W'(1);
                    next_fl_left  = red_code - 4'h1;
                end
            end
            FL_ON: begin
                if (fl_done) begin
                    next_fl_state = FL_OFF;
                    next_fl_tmr   = FLASH_ON - FT_W'(1);
                end
            end
            FL_OFF: begin
                if (fl_done && fl_left != 4'h0) begin
                    next_fl_state = FL_ON;
                    next_fl_tmr   = FLASH_ON - FT_W'(1);
                    next_fl_left  = fl_left - 4'h1;
                end else if (fl_done) begin
                    next_fl_state = FL_PAUSE;
                    next_fl_tmr   = FLASH_PAUSE - FT_W'(1);
                end
            end
            FL_PAUSE: begin
                if (fl_done) begin
                    next_fl_state = FL_IDLE;
                end
            end
            default: begin
                next_fl_state = FL_IDLE;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fl_state <= FL_IDLE;
            fl_tmr   <= '0;
            fl_left  <= 4'h0;
        end else begin
            fl_state <= next_fl_state;
            fl_tmr   <= next_fl_tmr;
            fl_left  <= next_fl_left;
        end
    end

    // Registered pin outputs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            safety_channel_a <= 1'b0;
            safety_channel_b <= 1'b0;
            status_out       <= 1'b0;
            led_green        <= 1'b0;
            led_yellow       <= 1'b0;
            led_red          <= 1'b0;
        end else begin
            safety_channel_a <= ch_on;
            safety_channel_b <= ch_on;
            status_out       <= next_stat;
            led_green        <= 1'b1;
            led_yellow       <= next_yel;
            led_red          <= next_red;
        end
    end

    // Bus slave: zero wait states, always OKAY
    wire addr_ok  = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    wire wr_ctrl  = bq.wr && (bq.addr == REG_CTRL);
    wire [31:0] next_ctrl = wr_ctrl ? hwdata : ctrl;
    logic [31:0] status_word;
    logic [31:0] cause_word;
    always_comb begin
        status_word = '0;
        status_word[ST_GUARD]  = p.guard_closed;
        status_word[ST_ACT]    = p.actuator_present;
        status_word[ST_LOCKED] = locked;
        status_word[ST_CH_A]   = safety_channel_a;
        status_word[ST_CH_B]   = safety_channel_b;
        status_word[ST_STATUS] = status_out;
        status_word[ST_WARN]   = warn_cause;
        status_word[ST_FAIL]   = fail_latched;
        status_word[ST_INTERN] = p.internal_failure;
        status_word[ST_POWER]  = fail_power;
        status_word[ST_CODE_LO +: CODE_W] = red_code;
        cause_word = 32'(sync2);
    end
    wire [7:0]  rd_addr = haddr[7:0];
    wire [31:0] rd_word = (rd_addr == REG_CTRL)   ? next_ctrl :
                          (rd_addr == REG_STATUS) ? status_word :
                          (rd_addr == REG_CAUSE)  ? cause_word : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bq        <= '0;
            ctrl      <= CTRL_RESET;
            hrdata    <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            bq.wr     <= addr_ok && hwrite;
            bq.rd     <= addr_ok && !hwrite;
            bq.addr   <= haddr[7:0];
            ctrl      <= next_ctrl;
            hrdata    <= (addr_ok && !hwrite) ? rd_word : hrdata;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
endmodule

// [ilk_pkg.sv]
// Shared constants, types and register map of the interlock diagnostic block
package ilk_pkg;
    localparam longint unsigned CLK_HZ        = 200_000_000;
    localparam longint unsigned WARN_TIME_MIN = 30;
    localparam longint unsigned WARN_CYC      = WARN_TIME_MIN * 60 * CLK_HZ;
    localparam longint unsigned FLASH_ON_MS   = 250;
    localparam longint unsigned FLASH_PAUSE_MS = 1000;
    localparam longint unsigned YEL_HALF_MS   = 250;
    localparam longint unsigned FLASH_ON_CYC  = FLASH_ON_MS * (CLK_HZ / 1000);
    localparam longint unsigned FLASH_PAUSE_CYC = FLASH_PAUSE_MS * (CLK_HZ / 1000);
    localparam longint unsigned YEL_HALF_CYC  = YEL_HALF_MS * (CLK_HZ / 1000);
    localparam int TMR_W = 40;
    localparam int FT_W  = 32;

    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_CAUSE  = 8'h08;

    localparam int CTRL_LOCK   = 0;
    localparam int CTRL_ENABLE = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

    localparam int ST_GUARD   = 0;
    localparam int ST_ACT     = 1;
    localparam int ST_LOCKED  = 2;
    localparam int ST_CH_A    = 3;
    localparam int ST_CH_B    = 4;
    localparam int ST_STATUS  = 5;
    localparam int ST_WARN    = 6;
    localparam int ST_FAIL    = 7;
    localparam int ST_INTERN  = 8;
    localparam int ST_POWER   = 9;
    localparam int ST_CODE_LO = 12;
    localparam int CODE_W     = 4;

    localparam logic [3:0] CODE_NONE  = 4'h0;
    localparam logic [3:0] CODE_A     = 4'h1;
    localparam logic [3:0] CODE_B     = 4'h2;
    localparam logic [3:0] CODE_CROSS = 4'h3;
    localparam logic [3:0] CODE_ACT   = 4'h5;
    localparam logic [3:0] CODE_FORCE = 4'h6;
    localparam logic [3:0] CODE_TEMP  = 4'hA;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    typedef struct packed {
        logic guard_closed;
        logic actuator_present;
        logic actuator_near_limit;
        logic lock_achieved;
        logic solenoid_cmd;
        logic force_fault;
        logic magnet_over_temp;
        logic test_fault_a;
        logic test_fault_b;
        logic cross_connect;
        logic actuator_wrong;
        logic internal_failure;
    } ilk_pins_t;

    localparam int PIN_W = $bits(ilk_pins_t);

    typedef enum logic [1:0] {
        FL_IDLE  = 2'b00,
        FL_ON    = 2'b01,
        FL_OFF   = 2'b10,
        FL_PAUSE = 2'b11
    } ilk_fl_state_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
    } ilk_bus_q_t;
endpackage

// [ilk_diag_assertions.sv]
// Concurrent checks on the interlock outputs
`timescale 1ns/1ps
module ilk_diag_assertions
    import ilk_pkg::*;
(
    input wire logic      hclk,
    input wire logic      hresetn,
    input wire logic      hreadyout,
    input wire logic      hresp,
    input wire ilk_pins_t pins,
    input wire logic      safety_channel_a,
    input wire logic      safety_channel_b,
    input wire logic      status_out,
    input wire logic      led_green,
    input wire logic      led_yellow,
    input wire logic      led_red
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire logic ch_off = !safety_channel_a && !safety_channel_b;
    sequence s_open;
        !pins.guard_closed [*5];
    endsequence
    sequence s_intern;
        pins.internal_failure [*2];
    endsequence
    property p_green;
        $past(hresetn) |-> led_green;
    endproperty
    a_green: assert property (p_green) else $error("green led dark");
    property p_dark;
        s_open |-> ch_off && !status_out && !led_yellow && !led_red;
    endproperty
    a_dark: assert property (p_dark) else $error("outputs active, guard open");
    property p_status;
        status_out |-> $past(pins.guard_closed, 3);
    endproperty
    a_status: assert property (p_status) else $error("status high, guard open");
    property p_ch_cause;
        safety_channel_a |-> $past(pins.guard_closed, 3) && $past(pins.lock_achieved, 3);
    endproperty
    a_ch_cause: assert property (p_ch_cause) else $error("channel on, not locked");
    property p_pair;
        safety_channel_a == safety_channel_b;
    endproperty
    a_pair: assert property (p_pair) else $error("channels differ");
    property p_wrong;
        pins.actuator_wrong |-> ##4 ch_off;
    endproperty
    a_wrong: assert property (p_wrong) else $error("channels on, bad actuator");
    property p_force;
        pins.force_fault |-> ##4 ch_off;
    endproperty
    a_force: assert property (p_force) else $error("channels on, low force");
    property p_temp;
        pins.magnet_over_temp |-> ##4 ch_off;
    endproperty
    a_temp: assert property (p_temp) else $error("channels on, magnet hot");
    property p_intern;
        s_intern |-> ##3 ch_off;
    endproperty
    a_intern: assert property (p_intern) else $error("channels on, internal");
    property p_red_int;
        (pins.internal_failure && pins.guard_closed) [*5] |-> led_red;
    endproperty
    a_red_int: assert property (p_red_int) else $error("red dark, internal");
    property p_okay;
        hreadyout && !hresp;
    endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or error");
endmodule

bind ilk_diag ilk_diag_assertions u_chk (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .hreadyout       (hreadyout),
    .hresp           (hresp),
    .pins            (pins),
    .safety_channel_a(safety_channel_a),
    .safety_channel_b(safety_channel_b),
    .status_out      (status_out),
    .led_green       (led_green),
    .led_yellow      (led_yellow),
    .led_red         (led_red)
);

// [ilk_plc_model.sv]
// Controller model driving the interlock inputs
`timescale 1ns/1ps
module ilk_plc_model
    import ilk_pkg::*;
(
    input  wire logic hclk,
    output ilk_pins_t pins
);
    ilk_pins_t cur = '0;
    initial pins = '0;
    // Shadow keeps the latest request visible before its edge lands
    task automatic set_pins(input ilk_pins_t v);
        @(posedge hclk);
        pins <= v;
        cur = v;
    endtask
    // Open then close the guard
    task automatic guard_cycle();
        ilk_pins_t v;
        v = cur;
        v.guard_closed = 1'b0;
        set_pins(v);
        repeat (8) @(posedge hclk);
        v.guard_closed = 1'b1;
        set_pins(v);
    endtask
endmodule

// [tb_interlock_diagnostic_fsm.sv]
// Self-checking bench for the interlock diagnostic block
`timescale 1ns/1ps
module tb_interlock_diagnostic_fsm
    import ilk_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    ilk_pins_t   pins;
    logic        safety_channel_a;
    logic        safety_channel_b;
    logic        status_out;
    logic        led_green;
    logic        led_yellow;
    logic        led_red;
    logic [31:0] rd;
    int          failures = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n;
    logic [11:0] msk[6] = '{12'h010, 12'h008, 12'h002, 12'h040, 12'h020, 12'h004};
    logic [3:0]  cod[6] = '{CODE_A, CODE_B, CODE_ACT, CODE_FORCE, CODE_TEMP, CODE_CROSS};
    logic [5:0]  imm = 6'h1C;
    ilk_diag #(.WARN_CYCLES(40'hC8), .FLASH_ON(32'h4), .FLASH_PAUSE(32'hA), .YEL_HALF(32'h3)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .pins(pins),
        .safety_channel_a(safety_channel_a), .safety_channel_b(safety_channel_b),
        .status_out(status_out),
        .led_green(led_green), .led_yellow(led_yellow), .led_red(led_red)
    );
    ilk_plc_model u_plc (.hclk(hclk), .pins(pins));
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge hclk);
    endtask
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    // Yellow level changes over twelve cycles
    task automatic toggles(output int cnt);
        logic pv;
        cnt = 0;
        for (int k = 0; k < 12; k++) begin
            pv = led_yellow;
            @(posedge hclk);
            if (led_yellow !== pv) cnt++;
        end
    endtask
    // Pulses of one red burst, started inside a pause
    task automatic burst(output int cnt);
        int lo;
        logic pv;
        lo = 0;
        while (lo < 9) begin
            @(posedge hclk);
            lo = led_red ? 0 : lo + 1;
        end
        cnt = 0;
        lo = 0;
        pv = 1'b0;
        while (lo < 9) begin
            @(posedge hclk);
            if (led_red && !pv) cnt++;
            pv = led_red;
            lo = led_red ? 0 : lo + 1;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = '0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = '0;
        wt(8);
        hresetn <= 1'b1;
        wt(2);
        ahb(1'b0, REG_CTRL, 32'h0);
        check(rd, CTRL_RESET);
        ahb(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h0);
        $display("test registers done");
        u_plc.set_pins(ilk_pins_t'(12'hE00));
        wt(8);
        check({status_out, safety_channel_a, led_green}, 32'h5);
        toggles(n);
        check(32'(n), 32'h4);
        u_plc.set_pins(ilk_pins_t'(12'hD80));
        wt(8);
        check({safety_channel_a, safety_channel_b, status_out, led_yellow, led_red}, 32'h1E);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd[5:0], 32'h3F);
        check(hresp, 32'h0);
        ahb(1'b1, REG_CTRL, 32'h0);
        wt(6);
        check(safety_channel_a, 32'h0);
        ahb(1'b1, REG_CTRL, CTRL_RESET);
        u_plc.set_pins(ilk_pins_t'(12'hC80));
        wt(8);
        check({safety_channel_a, status_out}, 32'h0);
        toggles(n);
        check(32'(n), 32'h4);
        $display("test lock done");
        u_plc.set_pins(ilk_pins_t'(12'hD90));
        wt(8);
        check({safety_channel_a, status_out}, 32'h2);
        ahb(1'b0, REG_STATUS, 32'h0);
        check(rd[15:12], CODE_A);
        wt(100);
        u_plc.set_pins(ilk_pins_t'(12'hD80));
        wt(8);
        check(status_out, 32'h1);
        u_plc.set_pins(ilk_pins_t'(12'hD90));
        wt(150);
        check(safety_channel_a, 32'h1);
        wt(60);
        check(safety_channel_a, 32'h0);
        u_plc.set_pins(ilk_pins_t'(12'hD80));
        wt(8);
        check(safety_channel_a, 32'h0);
        u_plc.guard_cycle();
        wt(8);
        check(safety_channel_a, 32'h1);
        $display("test warning done");
        for (int i = 0; i < 6; i++) begin
            u_plc.set_pins(ilk_pins_t'(12'hD80 | msk[i]));
            burst(n);
            check(32'(n), 32'(cod[i]));
            check(safety_channel_a, 32'(!imm[i]));
            if (i == 5) begin
                wt(200);
                check(safety_channel_a, 32'h0);
            end
            u_plc.set_pins(ilk_pins_t'(12'hD80));
            u_plc.guard_cycle();
            wt(8);
            check(safety_channel_a, 32'(i != 5));
        end
        hresetn <= 1'b0;
        wt(2);
        hresetn <= 1'b1;
        wt(8);
        check(safety_channel_a, 32'h1);
        $display("test codes done");
        u_plc.set_pins(ilk_pins_t'(12'hD81));
        wt(8);
        check({led_red, safety_channel_a}, 32'h2);
        u_plc.set_pins(ilk_pins_t'(12'h001));
        wt(8);
        check({led_red, led_yellow, status_out, led_green}, 32'h1);
        $display("test internal done");
        end_of_test();
    end
endmodule
